// *** rtl/uhpf_defs.svh ***
/*
  Register addresses, bit positions and write masks of the host pipe
  flag-force and mask block. Included by the package and the top module.
*/
`ifndef UHPF_DEFS_SVH
`define UHPF_DEFS_SVH

`define UHPF_PIPES 10
// Per-pipe register bases, one 32-bit word per pipe
`define UHPF_STATUS_BASE 32'h400A_C530
`define UHPF_CLEAR_BASE 32'h400A_C560
`define UHPF_FORCE_BASE 32'h400A_C590
`define UHPF_MASK_BASE 32'h400A_C5C0
`define UHPF_ENABLE_BASE 32'h400A_C5F0
`define UHPF_DISABLE_BASE 32'h400A_C620
// Status and mask bit positions; bits 0..7 shared by force, clear and mask low byte
`define UHPF_B_INRX 0
`define UHPF_B_OUTF 1
`define UHPF_B_SETUP 2
`define UHPF_B_PERR 3
`define UHPF_B_NAK 4
`define UHPF_B_OVF 5
`define UHPF_B_STALL 6
`define UHPF_B_SHORT 7
`define UHPF_B_BUSY 12
`define UHPF_B_BUSYEVT 15
`define UHPF_B_HANDOFF 14
`define UHPF_B_DMABLK 16
`define UHPF_B_HOLD 17
`define UHPF_B_TOGGLE 18
// Bits reachable through the enable and disable registers
`define UHPF_EN_MASK 19'h7_10FF
`define UHPF_DIS_MASK 19'h3_50FF
`define UHPF_RESET_VAL 32'h0000_0000

`endif

// *** rtl/uhpf_pkg.sv ***
/*
  Types of the host pipe flag-force and mask block.
  Assumes uhpf_defs.svh is on the include path.
*/
`include "uhpf_defs.svh"

package uhpf_pkg;

  typedef logic [7:0] uhpf_flags_t;
  typedef logic [18:0] uhpf_mask_t;

  typedef struct packed {
    logic [`UHPF_PIPES-1:0][7:0] flag;
    logic [`UHPF_PIPES-1:0] busyEvt;
    logic [`UHPF_PIPES-1:0] busyForce;
    logic [`UHPF_PIPES-1:0][18:0] mask;
    logic [`UHPF_PIPES-1:0] prevReset;
    logic [`UHPF_PIPES-1:0] prevEnable;
    logic [`UHPF_PIPES-1:0][8:0] inCnt;
    logic [31:0] rdData;
    logic irq;
    logic [`UHPF_PIPES-1:0] reqEn;
    logic [`UHPF_PIPES-1:0] toggle;
    logic [`UHPF_PIPES-1:0] bankSend;
    logic [`UHPF_PIPES-1:0] bankRelease;
    logic [`UHPF_PIPES-1:0] shortSend;
    logic [`UHPF_PIPES-1:0] dmaBlock;
  } uhpf_state_t;

endpackage

// *** rtl/uhpf_top.sv ***
/*
  Host pipe flag-force and mask logic for ten pipes: status flags,
  force, clear, enable, disable and mask registers, freeze and bank
  hand-off control, one level interrupt.
  Assumes all event and configuration inputs come from the pipe engine
  on ref_clk, so none of them is synchronised here.
*/
//
// Notes on behaviour
// - Ten write-only force registers, pipes 0..9
// - Force bits 0..7 set matching status flags
// - Force bit 12 forces busy-bank indication
// - Force zeros change nothing; reads return zero
// - Mask register read-only, changed via enable/disable
// - Toggle reinit bit set, toggle reset, self-clears
// - Hold set by seven listed causes
// - Held pipe makes no requests; clear resumes
// - OUT/SETUP handoff set on free; clear sends
// - IN handoff set on receive; clear frees bank
// - Busy-bank enable set and cleared by writes
// - Short packet sent at DMA end when allowed
// - Mask bit 6 is stall or CRC enable
// - Mask bit 16 lets interrupts block DMA
// - Status bit 6 CRC for iso, else stall
// - Clear register ones clear flags, zeros ignored
`timescale 1ns/1ps
`default_nettype none
`include "uhpf_defs.svh"

module uhpf_top (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [31:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdData,
  output logic pipeIrq,
  input wire logic [`UHPF_PIPES-1:0] evtInRx,
  input wire logic [`UHPF_PIPES-1:0] evtBankFree,
  input wire logic [`UHPF_PIPES-1:0] evtUnderflow,
  input wire logic [`UHPF_PIPES-1:0] evtPipeErr,
  input wire logic [`UHPF_PIPES-1:0] evtNak,
  input wire logic [`UHPF_PIPES-1:0] evtOverflow,
  input wire logic [`UHPF_PIPES-1:0] evtStall,
  input wire logic [`UHPF_PIPES-1:0] evtCrcErr,
  input wire logic [`UHPF_PIPES-1:0] evtShortPkt,
  input wire logic [`UHPF_PIPES-1:0] evtBusyBank,
  input wire logic [2*`UHPF_PIPES-1:0] bankBusyCount,
  input wire logic [`UHPF_PIPES-1:0] pipeIsIso,
  input wire logic [`UHPF_PIPES-1:0] pipeIsControl,
  input wire logic [`UHPF_PIPES-1:0] pipeIsOut,
  input wire logic [`UHPF_PIPES-1:0] pipeConfigured,
  input wire logic [`UHPF_PIPES-1:0] pipeEnable,
  input wire logic [`UHPF_PIPES-1:0] pipeReset,
  input wire logic [`UHPF_PIPES-1:0] autoBankSwitch,
  input wire logic [`UHPF_PIPES-1:0] dmaBufEndEn,
  input wire logic [`UHPF_PIPES-1:0] dmaEnd,
  input wire logic [`UHPF_PIPES-1:0] inReqDone,
  input wire logic [8*`UHPF_PIPES-1:0] inRequestCount,
  output logic [`UHPF_PIPES-1:0] pipeHold,
  output logic [`UHPF_PIPES-1:0] pipeReqEn,
  output logic [`UHPF_PIPES-1:0] toggleReinit,
  output logic [`UHPF_PIPES-1:0] bankSend,
  output logic [`UHPF_PIPES-1:0] bankRelease,
  output logic [`UHPF_PIPES-1:0] shortPktSend,
  output logic [`UHPF_PIPES-1:0] dmaReqBlock
);
  import uhpf_pkg::*;

  uhpf_state_t st_r;
  uhpf_state_t st_nxt;
  logic [31:0] pOff;
  logic wForce, wClear, wEn, wDis;
  logic rStatus, rMask;
  uhpf_flags_t setF, clrF;
  uhpf_mask_t m, enB, disB;
  logic holdSet, handSet, inLimit, irqP, anyIrq;
  logic [1:0] busyCnt;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    pOff = '0;
    wForce = 1'b0;
    wClear = 1'b0;
    wEn = 1'b0;
    wDis = 1'b0;
    rStatus = 1'b0;
    rMask = 1'b0;
    setF = '0;
    clrF = '0;
    m = '0;
    enB = '0;
    disB = '0;
    holdSet = 1'b0;
    handSet = 1'b0;
    inLimit = 1'b0;
    irqP = 1'b0;
    anyIrq = 1'b0;
    busyCnt = '0;
    // Unmapped reads and write-only registers answer zero
    st_nxt.rdData = '0;
    st_nxt.toggle = '0;
    st_nxt.bankSend = '0;
    st_nxt.bankRelease = '0;
    st_nxt.shortSend = '0;
    for (int p = 0; p < `UHPF_PIPES; p++) begin
      pOff = 32'(p) << 2;
      wForce = regWrStb && (regAddr == `UHPF_FORCE_BASE + pOff);
      wClear = regWrStb && (regAddr == `UHPF_CLEAR_BASE + pOff);
      wEn = regWrStb && (regAddr == `UHPF_ENABLE_BASE + pOff);
      wDis = regWrStb && (regAddr == `UHPF_DISABLE_BASE + pOff);
      rStatus = regRdStb && (regAddr == `UHPF_STATUS_BASE + pOff);
      rMask = regRdStb && (regAddr == `UHPF_MASK_BASE + pOff);

      // Hardware events; shared bits picked by pipe type
      setF = '0;
      setF[`UHPF_B_INRX] = evtInRx[p];
      setF[`UHPF_B_OUTF] = evtBankFree[p] && !pipeIsControl[p];
      setF[`UHPF_B_SETUP] = (evtBankFree[p] && pipeIsControl[p]) ||
                            evtUnderflow[p];
      setF[`UHPF_B_PERR] = evtPipeErr[p];
      setF[`UHPF_B_NAK] = evtNak[p];
      setF[`UHPF_B_OVF] = evtOverflow[p];
      setF[`UHPF_B_STALL] = pipeIsIso[p] ? evtCrcErr[p] : evtStall[p];
      setF[`UHPF_B_SHORT] = evtShortPkt[p];
      if (wForce) begin
        setF = setF | regWrData[7:0];
      end
      clrF = wClear ? regWrData[7:0] : 8'h00;
      // Set wins over a clear in the same cycle
      st_nxt.flag[p] = (st_r.flag[p] & ~clrF) | setF;

      if (wClear && regWrData[`UHPF_B_BUSY]) begin
        st_nxt.busyEvt[p] = 1'b0;
        st_nxt.busyForce[p] = 1'b0;
      end
      if (evtBusyBank[p] || (wForce && regWrData[`UHPF_B_BUSY])) begin
        st_nxt.busyEvt[p] = 1'b1;
      end
      if (wForce && regWrData[`UHPF_B_BUSY]) begin
        st_nxt.busyForce[p] = 1'b1;
      end

      // Mask changes through enable and disable writes, toggle self-clear and hardware hand-off and hold sets
      m = st_r.mask[p];
      if (m[`UHPF_B_TOGGLE]) begin
        st_nxt.toggle[p] = 1'b1;
        m[`UHPF_B_TOGGLE] = 1'b0;
      end
      enB = wEn ? (regWrData[18:0] & `UHPF_EN_MASK) : '0;
      disB = wDis ? (regWrData[18:0] & `UHPF_DIS_MASK) : '0;
      m = (m & ~disB) | enB;

      // Hand-off: clearing sends an OUT bank or frees an IN bank
      if (disB[`UHPF_B_HANDOFF] && st_r.mask[p][`UHPF_B_HANDOFF]) begin
        if (pipeIsOut[p]) begin
          st_nxt.bankSend[p] = 1'b1;
        end else begin
          st_nxt.bankRelease[p] = 1'b1;
        end
      end
      handSet = pipeIsOut[p] ? evtBankFree[p] : evtInRx[p];
      if (handSet) begin
        m[`UHPF_B_HANDOFF] = 1'b1;
      end

      // IN request limit: freeze after count plus one requests
      inLimit = 1'b0;
      if (inReqDone[p] && !pipeIsOut[p]) begin
        if (st_r.inCnt[p] == {1'b0, inRequestCount[p*8 +: 8]}) begin
          inLimit = 1'b1;
          st_nxt.inCnt[p] = '0;
        end else begin
          st_nxt.inCnt[p] = 9'(st_r.inCnt[p] + 9'd1);
        end
      end
      if (pipeEnable[p] && !st_r.prevEnable[p]) begin
        st_nxt.inCnt[p] = '0;
      end

      holdSet = enB[`UHPF_B_HOLD] || !pipeConfigured[p] ||
                (evtStall[p] && !pipeIsIso[p]) || setF[`UHPF_B_PERR] ||
                inLimit || (pipeReset[p] && !st_r.prevReset[p]) ||
                (pipeEnable[p] && !st_r.prevEnable[p]);
      // A cause of freezing outweighs a clear written alongside
      if (holdSet) begin
        m[`UHPF_B_HOLD] = 1'b1;
      end
      st_nxt.mask[p] = m;
      st_nxt.prevReset[p] = pipeReset[p];
      st_nxt.prevEnable[p] = pipeEnable[p];
      st_nxt.reqEn[p] = !m[`UHPF_B_HOLD] && pipeConfigured[p] &&
                        pipeEnable[p];

      // Short packet closes a DMA transfer on bulk-like OUT pipes
      st_nxt.shortSend[p] = dmaEnd[p] && pipeIsOut[p] &&
                            !pipeIsControl[p] && m[`UHPF_B_SHORT] &&
                            dmaBufEndEn[p] && autoBankSwitch[p];

      irqP = |(st_nxt.flag[p] & m[7:0]) ||
             (st_nxt.busyEvt[p] && m[`UHPF_B_BUSY]);
      st_nxt.dmaBlock[p] = m[`UHPF_B_DMABLK] && irqP;
      anyIrq = anyIrq || irqP;

      busyCnt = bankBusyCount[p*2 +: 2] | {1'b0, st_r.busyForce[p]};
      if (rStatus) begin
        st_nxt.rdData = {16'h0000, st_r.busyEvt[p], 1'b0, busyCnt,
                         4'h0, st_r.flag[p]};
      end else if (rMask) begin
        st_nxt.rdData = {13'h0000, st_r.mask[p]};
      end
    end
    st_nxt.irq = anyIrq;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= uhpf_state_t'(`UHPF_RESET_VAL);
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign regRdData = st_r.rdData;
  assign pipeIrq = st_r.irq;
  assign pipeReqEn = st_r.reqEn;
  assign toggleReinit = st_r.toggle;
  assign bankSend = st_r.bankSend;
  assign bankRelease = st_r.bankRelease;
  assign shortPktSend = st_r.shortSend;
  assign dmaReqBlock = st_r.dmaBlock;

  genvar g;
  generate
    for (g = 0; g < `UHPF_PIPES; g++) begin : gHold
      assign pipeHold[g] = st_r.mask[g][`UHPF_B_HOLD];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Assertions, watching pipe 0
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_force_sets_flag: assert property (
    regWrStb && regAddr == `UHPF_FORCE_BASE && regWrData[`UHPF_B_NAK]
    |=> st_r.flag[0][`UHPF_B_NAK])
    else $error("force write did not set flag");

  a_force_busy_count: assert property (
    regWrStb && regAddr == `UHPF_FORCE_BASE && regWrData[`UHPF_B_BUSY]
    ##1 regRdStb && regAddr == `UHPF_STATUS_BASE
    |=> regRdData[`UHPF_B_BUSY] && regRdData[`UHPF_B_BUSYEVT])
    else $error("busy bank force not visible");

  a_force_reads_zero: assert property (
    regRdStb && regAddr == `UHPF_FORCE_BASE |=> regRdData == 32'h0000_0000)
    else $error("force register read not zero");

  a_force_zero_inert: assert property (
    regWrStb && regAddr == `UHPF_FORCE_BASE && regWrData[7:0] == 8'h00 &&
    !evtNak[0] |=> st_r.flag[0][`UHPF_B_NAK] == $past(st_r.flag[0][4]) ||
    $past(regWrStb && regAddr == `UHPF_CLEAR_BASE))
    else $error("zero force changed a flag");

  a_mask_read: assert property (
    regRdStb && regAddr == `UHPF_MASK_BASE
    |=> regRdData[18:0] == $past(st_r.mask[0]) && regRdData[31:19] == 0)
    else $error("mask read wrong");

  a_toggle_cycle: assert property (
    regWrStb && regAddr == `UHPF_ENABLE_BASE && regWrData[`UHPF_B_TOGGLE]
    |=> st_r.mask[0][`UHPF_B_TOGGLE] ##1
    (toggleReinit[0] && !st_r.mask[0][`UHPF_B_TOGGLE]))
    else $error("toggle reinit not done and cleared");

  a_hold_on_stall: assert property (
    evtStall[0] && !pipeIsIso[0] |=> pipeHold[0] [*1] ##0 !pipeReqEn[0])
    else $error("stall did not freeze pipe");

  a_hold_blocks_req: assert property (
    pipeHold[0] |-> !pipeReqEn[0])
    else $error("held pipe still requesting");

  a_handoff_send: assert property (
    st_r.mask[0][`UHPF_B_HANDOFF] && pipeIsOut[0] && regWrStb &&
    regAddr == `UHPF_DISABLE_BASE && regWrData[`UHPF_B_HANDOFF]
    |=> bankSend[0] ##1 !bankSend[0])
    else $error("handoff clear did not send bank");

  a_handoff_in: assert property (
    evtInRx[0] && !pipeIsOut[0]
    |=> st_r.mask[0][`UHPF_B_HANDOFF] && st_r.flag[0][`UHPF_B_INRX])
    else $error("IN arrival did not set handoff");

  a_busy_enable: assert property (
    regWrStb && regAddr == `UHPF_ENABLE_BASE && regWrData[`UHPF_B_BUSY]
    |=> st_r.mask[0][`UHPF_B_BUSY])
    else $error("busy bank enable not set");

  a_short_send: assert property (
    dmaEnd[0] && pipeIsOut[0] && !pipeIsControl[0] &&
    st_r.mask[0][`UHPF_B_SHORT] && dmaBufEndEn[0] && autoBankSwitch[0] &&
    !(regWrStb && regAddr == `UHPF_DISABLE_BASE) |=> shortPktSend[0])
    else $error("short packet not sent");

  a_stall_en_clear: assert property (
    regWrStb && regAddr == `UHPF_DISABLE_BASE && regWrData[`UHPF_B_STALL] &&
    !(st_r.mask[0][`UHPF_B_TOGGLE]) |=> !st_r.mask[0][`UHPF_B_STALL])
    else $error("bit 6 enable not cleared");

  a_dma_block: assert property (
    dmaReqBlock[0] |-> st_r.mask[0][`UHPF_B_DMABLK] && pipeIrq)
    else $error("DMA blocked without cause");

  a_crc_iso: assert property (
    evtCrcErr[0] && pipeIsIso[0] |=> st_r.flag[0][`UHPF_B_STALL])
    else $error("iso CRC error not flagged");

  a_clear_flag: assert property (
    regWrStb && regAddr == `UHPF_CLEAR_BASE && regWrData[`UHPF_B_NAK] &&
    !evtNak[0] |=> !st_r.flag[0][`UHPF_B_NAK])
    else $error("clear write did not clear flag");

  a_irq_level: assert property (
    st_r.flag[0][`UHPF_B_NAK] && st_r.mask[0][`UHPF_B_NAK] |-> pipeIrq)
    else $error("enabled flag without interrupt");

endmodule // uhpf_top

`default_nettype wire

// *** dv/uhpf_pipe_engine.sv ***
/*
  Model of the pipe engine facing the attached device: event pulses
  and pipe configuration levels per pipe.
  Assumes it shares ref_clk with uhpf_top.
*/
`timescale 1ns/1ps
`default_nettype none

module uhpf_pipe_engine (
  input wire logic ref_clk,
  output logic [11:0][9:0] evt,
  output logic [9:0] pipeReset,
  output logic [9:0] isIso,
  output logic [9:0] isCtl,
  output logic [9:0] isOut,
  output logic [9:0] cfg,
  output logic [9:0] enable,
  output logic [9:0] auto_bank_switch,
  output logic [9:0] bufEndEn,
  output logic [19:0] busyCnt,
  output logic [79:0] reqCnt
);
  // ----------------------------------------
  // Fixed pipe map
  // ----------------------------------------
  // Pipe 3 unconfigured, pipe 7 lacks auto switch to refuse short send
  // Pipe 8 is a control pipe; pipe 3 reports two busy banks
  assign isIso = 10'h002;
  assign isCtl = 10'h100;
  assign isOut = 10'h1D0;
  assign cfg = 10'h3F7;
  assign enable = 10'h3FF;
  assign auto_bank_switch = 10'h37F;
  assign bufEndEn = 10'h3FF;
  assign busyCnt = 20'h0_0080;
  assign reqCnt = {10{8'h02}};

  initial begin
    evt = '0;
    pipeReset = '0;
  end

  // One-cycle event pulse, kind k on pipe p
  task automatic fire(input int k, input int p);
    @(posedge ref_clk);
    evt[k][p] <= 1'b1;
    @(posedge ref_clk);
    evt[k][p] <= 1'b0;
  endtask

  task automatic raiseReset(input int p);
    @(posedge ref_clk);
    pipeReset[p] <= 1'b1;
  endtask
endmodule // uhpf_pipe_engine

`default_nettype wire

// *** dv/tb_uhpf_top.sv ***
/*
  Self-checking bench of uhpf_top: register tasks, pipe events via
  the engine model, pulse counters on the control outputs.
  Assumes uhpf_defs.svh on the include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uhpf_defs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("Error %s expected %h seen %h", n, e, g); end end

module tb_uhpf_top;
  import uhpf_pkg::*;
  logic ref_clk, reset_n, regWrStb, regRdStb, pipeIrq;
  logic [31:0] regAddr, regWrData, regRdData, m;
  wire logic [11:0][9:0] ev;
  wire logic [9:0] prst, iso, ctl, isOut, cfg, en, asw, bufEn;
  wire logic [9:0] hold, reqEn, tgl, bSend, bRel, sSend, dBlk;
  wire logic [19:0] bCnt;
  wire logic [79:0] rqCnt;
  int checked, miscompares, cyc, nTgl, nSend, nRel, nShort, b, p;
  int bits[9] = '{0, 1, 2, 3, 4, 5, 6, 7, 12};
  int kinds[6] = '{2, 3, 4, 5, 8, 9};
  int kbit[6] = '{2, 3, 4, 5, 7, 15};

  uhpf_pipe_engine eng (.ref_clk(ref_clk), .evt(ev), .pipeReset(prst),
    .isIso(iso), .isCtl(ctl), .isOut(isOut), .cfg(cfg), .enable(en),
    .auto_bank_switch(asw), .bufEndEn(bufEn), .busyCnt(bCnt), .reqCnt(rqCnt));

  uhpf_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .pipeIrq(pipeIrq), .evtInRx(ev[0]),
    .evtBankFree(ev[1]), .evtUnderflow(ev[2]), .evtPipeErr(ev[3]),
    .evtNak(ev[4]), .evtOverflow(ev[5]), .evtStall(ev[6]),
    .evtCrcErr(ev[7]), .evtShortPkt(ev[8]), .evtBusyBank(ev[9]),
    .bankBusyCount(bCnt), .pipeIsIso(iso), .pipeIsControl(ctl),
    .pipeIsOut(isOut), .pipeConfigured(cfg), .pipeEnable(en),
    .pipeReset(prst), .autoBankSwitch(asw), .dmaBufEndEn(bufEn),
    .dmaEnd(ev[10]), .inReqDone(ev[11]), .inRequestCount(rqCnt),
    .pipeHold(hold), .pipeReqEn(reqEn), .toggleReinit(tgl),
    .bankSend(bSend), .bankRelease(bRel), .shortPktSend(sSend),
    .dmaReqBlock(dBlk));

  // ----------------------------------------
  // Clock, pulse counters, timeout
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    nTgl += $countones(tgl);
    nSend += $countones(bSend);
    nRel += $countones(bRel);
    nShort += $countones(sSend);
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end

  // ----------------------------------------
  // Register access tasks
  // ----------------------------------------
  function automatic logic [31:0] ra(input logic [31:0] base, input int q);
    return base + 32'(4 * q);
  endfunction

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input string n, input logic [31:0] a,
      input logic [31:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    #1 `CHK(n, e, regRdData)
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic test_done();
    $display("Checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    regAddr = '0;
    regWrData = '0;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    idle(2);
    reset_n <= 1'b1;
    idle(3);
    `CHK("hold unconfigured", 1'b1, hold[3])
    for (int q = 0; q < 10; q++) begin
      wr(ra(`UHPF_DISABLE_BASE, q), 32'h0002_0000);
    end
    rdc("unmapped", 32'h400A_C650, 32'h0000_0000);
    for (int i = 0; i < 9; i++) begin
      b = bits[i];
      p = (i < 3) ? i : i + 1;
      m = 32'h0000_0001 << b;
      wr(ra(`UHPF_ENABLE_BASE, p), m);
      wr(ra(`UHPF_MASK_BASE, p), 32'hFFFF_FFFF);
      rdc("mask set", ra(`UHPF_MASK_BASE, p), m);
      wr(ra(`UHPF_FORCE_BASE, p), m);
      wr(ra(`UHPF_FORCE_BASE, p), 32'h0000_0000);
      idle(2);
      `CHK("irq", 1'b1, pipeIrq)
      rdc("status", ra(`UHPF_STATUS_BASE, p),
        (b == 12) ? 32'h0000_9000 : m);
      rdc("force read", ra(`UHPF_FORCE_BASE, p), 32'h0000_0000);
      rdc("mask hold", ra(`UHPF_MASK_BASE, p),
        (b == 3) ? (m | 32'h0002_0000) : m);
      wr(ra(`UHPF_CLEAR_BASE, p), m);
      rdc("status clear", ra(`UHPF_STATUS_BASE, p), 32'h0000_0000);
      `CHK("irq clear", 1'b0, pipeIrq)
      wr(ra(`UHPF_DISABLE_BASE, p), m | 32'h0002_0000);
      rdc("mask clear", ra(`UHPF_MASK_BASE, p), 32'h0000_0000);
    end
    for (int i = 0; i < 6; i++) begin
      eng.fire(kinds[i], 9);
      rdc("event flag", ra(`UHPF_STATUS_BASE, 9),
        32'h0000_0001 << kbit[i]);
      wr(ra(`UHPF_CLEAR_BASE, 9), 32'h0000_10FF);
      wr(ra(`UHPF_DISABLE_BASE, 9), 32'h0002_0000);
    end
    eng.fire(6, 0);
    idle(2);
    `CHK("hold stall", 1'b1, hold[0])
    `CHK("no requests", 1'b0, reqEn[0])
    rdc("stall bit", ra(`UHPF_STATUS_BASE, 0), 32'h0000_0040);
    wr(ra(`UHPF_CLEAR_BASE, 0), 32'h0000_0040);
    wr(ra(`UHPF_DISABLE_BASE, 0), 32'h0002_0000);
    idle(2);
    `CHK("requests back", 1'b1, reqEn[0])
    eng.fire(7, 1);
    rdc("crc iso", ra(`UHPF_STATUS_BASE, 1), 32'h0000_0040);
    repeat (2) eng.fire(11, 0);
    idle(2);
    `CHK("in count n", 1'b0, hold[0])
    eng.fire(11, 0);
    idle(2);
    `CHK("in count n+1", 1'b1, hold[0])
    eng.raiseReset(1);
    wr(ra(`UHPF_ENABLE_BASE, 2), 32'h0002_0000);
    idle(2);
    `CHK("hold reset", 1'b1, hold[1])
    `CHK("hold software", 1'b1, hold[2])
    wr(ra(`UHPF_DISABLE_BASE, 2), 32'h0002_0000);
    eng.fire(0, 2);
    rdc("in handoff", ra(`UHPF_MASK_BASE, 2), 32'h0000_4000);
    wr(ra(`UHPF_DISABLE_BASE, 2), 32'h0000_4000);
    eng.fire(1, 4);
    rdc("out flag", ra(`UHPF_STATUS_BASE, 4), 32'h0000_0002);
    rdc("out handoff", ra(`UHPF_MASK_BASE, 4), 32'h0000_4000);
    wr(ra(`UHPF_DISABLE_BASE, 4), 32'h0000_4000);
    wr(ra(`UHPF_ENABLE_BASE, 5), 32'h0004_0000);
    wr(ra(`UHPF_ENABLE_BASE, 6), 32'h0000_0080);
    wr(ra(`UHPF_ENABLE_BASE, 7), 32'h0000_0080);
    eng.fire(10, 6);
    eng.fire(10, 7);
    idle(3);
    `CHK("bank release", 1, nRel)
    `CHK("bank send", 1, nSend)
    `CHK("toggle pulse", 1, nTgl)
    `CHK("short send", 1, nShort)
    rdc("toggle done", ra(`UHPF_MASK_BASE, 5), 32'h0000_0000);
    wr(ra(`UHPF_ENABLE_BASE, 8), 32'h0001_0001);
    wr(ra(`UHPF_FORCE_BASE, 8), 32'h0000_0001);
    idle(3);
    `CHK("dma block", 1'b1, dBlk[8])
    wr(ra(`UHPF_CLEAR_BASE, 8), 32'h0000_0001);
    idle(3);
    `CHK("dma unblock", 1'b0, dBlk[8])
    wr(ra(`UHPF_ENABLE_BASE, 0), 32'h0004_1050);
    wr(ra(`UHPF_FORCE_BASE, 0), 32'h0000_1010);
    wr(ra(`UHPF_FORCE_BASE, 0), 32'h0000_0000);
    rdc("pipe0 status", ra(`UHPF_STATUS_BASE, 0), 32'h0000_9010);
    `CHK("pipe0 irq", 1'b1, pipeIrq)
    `CHK("toggle pulse 2", 2, nTgl)
    wr(ra(`UHPF_DISABLE_BASE, 0), 32'h0000_1040);
    wr(ra(`UHPF_CLEAR_BASE, 0), 32'h0000_1010);
    rdc("pipe0 mask", ra(`UHPF_MASK_BASE, 0), 32'h0002_0010);
    `CHK("pipe0 irq clear", 1'b0, pipeIrq)
    eng.fire(1, 8);
    rdc("setup flag", ra(`UHPF_STATUS_BASE, 8), 32'h0000_0004);
    rdc("setup handoff", ra(`UHPF_MASK_BASE, 8), 32'h0001_4001);
    rdc("busy count", ra(`UHPF_STATUS_BASE, 3), 32'h0000_2000);
    test_done();
  end
endmodule // tb_uhpf_top

`default_nettype wire
